/* design/tmc_pkg.sv */
// package: register map, fields and constants of the timer 1 block
package tmc_pkg;
    // register word indices, byte address is index times four
    localparam logic [3:0] IDX_CTRL = 4'h5;
    localparam logic [3:0] IDX_BUF_A = 4'h6;
    localparam logic [3:0] IDX_BUF_B = 4'h7;
    localparam logic [3:0] IDX_STAT = 4'h8;
    localparam logic [3:0] IDX_MASK = 4'h9;
    localparam logic [3:0] IDX_COUNT = 4'hA;
    // control field positions
    localparam int CTRL_CAP_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_CK_HI = 5;
    localparam int CTRL_CK_LO = 4;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_EDGE_BIT = 2;
    // status bits
    localparam int ST_MATCH = 0;
    localparam int ST_CAPA = 1;
    localparam int ST_OVF = 2;
    localparam int ST_CAPB = 3;
    // prescaler exponents
    localparam int PRE_SEL0 = 12;
    localparam int PRE_SEL1 = 10;
    localparam int PRE_SEL2 = 7;
    localparam int PRE_W = 12;
    // reset values and overflow marker
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [7:0] OVF_VALUE = 8'hFF;
    // clock source selection
    typedef enum logic [1:0] {
        TMC_SRC_D12 = 2'b00,
        TMC_SRC_D10 = 2'b01,
        TMC_SRC_D7 = 2'b10,
        TMC_SRC_PIN = 2'b11
    } tmc_src_t;
    // capture engine state
    typedef enum logic [0:0] {
        TMC_ARMED = 1'b0,
        TMC_HALTED = 1'b1
    } tmc_cap_t;
    // decoded control bits
    typedef struct packed {
        logic soft_cap;
        logic run;
        tmc_src_t src;
        logic mode;
        logic edge_sel;
    } tmc_ctrl_t;
endpackage

/* design/tmc_timer1.sv */
// timer 1: 8-bit timer, counter and capture unit with wishbone slave
`timescale 1ns/1ns
// Overview of operation
// - clock field picks prescale or input pin
// - mode bit selects timer/counter or capture
// - edge bit picks rising or falling pin
// - timer match with A interrupts, clears counter
// - soft capture copies count to B outside capture mode, self-clears
// - counter mode counts one pin edge only
// - capture primary edge loads A, clears, interrupts
// - opposite edge loads B, counter keeps going
// - overflow before edge loads FFH into A
// - captures halt until buffer A is read or run goes low
// - both buffers are eight bits wide
// - run low stops and zeroes the counter
module tmc_timer1 #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // timer input pin and interrupt
    input wire logic tmr1_input_pin_i,
    output logic irq_o
);
    // elaboration check: the logic serves an 8-bit counter only
    if (CNT_W != 8) begin : g_bad_width
        $error("counter width must be 8");
    end

    // control register
    logic [7:0] ctrl_ff;
    tmc_pkg::tmc_ctrl_t ctl;
    assign ctl = tmc_pkg::tmc_ctrl_t'(ctrl_ff[7:2]);
    // buffers, counter, status, mask
    logic [7:0] tmr1_buffer_a_ff;
    logic [7:0] tmr1_buffer_b_ff;
    logic [7:0] count_ff;
    logic [3:0] stat_ff;
    logic [3:0] mask_ff;
    logic [tmc_pkg::PRE_W-1:0] pre_ff; // prescaler
    logic pin_ff; // previous pin level
    tmc_pkg::tmc_cap_t cap_ff; // capture engine state
    // bus decode
    logic req;
    logic hit;
    logic [3:0] idx;
    logic wr_lo;
    logic rd_a;
    logic rd_stat;
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign idx = adr_i[5:2];

    // decode a word index into mapped or not
    function automatic logic is_mapped(input logic [3:0] i);
        is_mapped = (i == tmc_pkg::IDX_CTRL) || (i == tmc_pkg::IDX_BUF_A)
            || (i == tmc_pkg::IDX_BUF_B) || (i == tmc_pkg::IDX_STAT)
            || (i == tmc_pkg::IDX_MASK) || (i == tmc_pkg::IDX_COUNT);
    endfunction

    assign hit = is_mapped(idx);
    assign wr_lo = req && hit && we_i && sel_i[0];
    assign rd_a = req && !we_i && (idx == tmc_pkg::IDX_BUF_A);
    assign rd_stat = req && !we_i && (idx == tmc_pkg::IDX_STAT);

    // prescaler taps, one-cycle tick pulses
    logic [tmc_pkg::PRE_W-1:0] nxt_pre;
    logic tick;
    logic pin_rise;
    logic pin_fall;
    logic sel_edge;
    logic opp_edge;
    assign nxt_pre = pre_ff + 1'b1;
    always_comb begin
        case (ctl.src)
            tmc_pkg::TMC_SRC_D12: tick = nxt_pre[tmc_pkg::PRE_SEL0-1:0] == '0;
            tmc_pkg::TMC_SRC_D10: tick = nxt_pre[tmc_pkg::PRE_SEL1-1:0] == '0;
            tmc_pkg::TMC_SRC_D7: tick = nxt_pre[tmc_pkg::PRE_SEL2-1:0] == '0;
            default: tick = 1'b0;
        endcase
    end
    assign pin_rise = tmr1_input_pin_i && !pin_ff;
    assign pin_fall = !tmr1_input_pin_i && pin_ff;
    // edge bit chooses counting or primary edge
    assign sel_edge = ctl.edge_sel ? pin_fall : pin_rise;
    assign opp_edge = ctl.edge_sel ? pin_rise : pin_fall;

    // count step: internal tick, or pin edge in counter mode
    logic step;
    logic capture_mode;
    assign capture_mode = ctl.mode;
    always_comb begin
        if (capture_mode) begin
            step = tick;
        end else if (ctl.src == tmc_pkg::TMC_SRC_PIN) begin
            step = sel_edge;
        end else begin
            step = tick;
        end
    end

    // event decode
    logic match_ev;
    logic capa_ev;
    logic capb_ev;
    logic ovf_ev;
    logic armed;
    assign armed = cap_ff == tmc_pkg::TMC_ARMED;
    assign match_ev = ctl.run && !capture_mode
        && step && (count_ff == tmr1_buffer_a_ff);
    assign capa_ev = ctl.run && capture_mode && armed && sel_edge;
    assign capb_ev = ctl.run && capture_mode && armed && opp_edge
        && !capa_ev;
    // wrap from all ones to zero
    assign ovf_ev = ctl.run && capture_mode && armed && !capa_ev
        && step && (count_ff == 8'hFF);

    // prescaler runs free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    // pin history for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= tmr1_input_pin_i;
        end
    end

    // control register, soft capture self-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= tmc_pkg::CTRL_RST;
        end else if (wr_lo && idx == tmc_pkg::IDX_CTRL) begin
            ctrl_ff <= {dat_i[7:2], 2'b00};
        end else if (ctl.soft_cap) begin
            ctrl_ff[tmc_pkg::CTRL_CAP_BIT] <= 1'b0;
        end
    end

    // counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else if (!ctl.run) begin
            count_ff <= '0;
        end else if (match_ev || capa_ev) begin
            count_ff <= '0;
        end else if (step) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // buffer a: software write, capture or overflow marker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr1_buffer_a_ff <= tmc_pkg::BUF_RST;
        end else if (capa_ev) begin
            tmr1_buffer_a_ff <= count_ff;
        end else if (ovf_ev) begin
            tmr1_buffer_a_ff <= tmc_pkg::OVF_VALUE;
        end else if (wr_lo && idx == tmc_pkg::IDX_BUF_A) begin
            tmr1_buffer_a_ff <= dat_i[7:0];
        end
    end

    // buffer b: soft capture, opposite edge, or write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr1_buffer_b_ff <= tmc_pkg::BUF_RST;
        end else if (ctl.soft_cap && !capture_mode) begin
            tmr1_buffer_b_ff <= count_ff;
        end else if (capb_ev) begin
            tmr1_buffer_b_ff <= count_ff;
        end else if (wr_lo && idx == tmc_pkg::IDX_BUF_B) begin
            tmr1_buffer_b_ff <= dat_i[7:0];
        end
    end

    // capture engine halts after an a-event until a is read or run goes low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_ff <= tmc_pkg::TMC_ARMED;
        end else begin
            case (cap_ff)
                tmc_pkg::TMC_ARMED: begin
                    if (capa_ev || ovf_ev) begin
                        cap_ff <= tmc_pkg::TMC_HALTED;
                    end
                end
                tmc_pkg::TMC_HALTED: begin
                    if (rd_a || !ctl.run) begin
                        cap_ff <= tmc_pkg::TMC_ARMED;
                    end
                end
                default: cap_ff <= tmc_pkg::TMC_ARMED;
            endcase
        end
    end

    // sticky status: set wins over read-clear
    logic [3:0] ev_vec;
    assign ev_vec = {capb_ev, ovf_ev, capa_ev, match_ev};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_ff <= tmc_pkg::STAT_RST;
        end else if (rd_stat) begin
            stat_ff <= ev_vec;
        end else begin
            stat_ff <= stat_ff | ev_vec;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= tmc_pkg::MASK_RST;
        end else if (wr_lo && idx == tmc_pkg::IDX_MASK) begin
            mask_ff <= dat_i[3:0];
        end
    end

    // interrupt output, registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_ff & mask_ff);
        end
    end

    // bus answer: one-cycle ack or err, registered data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req && hit;
            err_o <= req && !hit;
            dat_o <= '0;
            if (req && !we_i) begin
                case (idx)
                    tmc_pkg::IDX_CTRL: dat_o <= {24'h000000, ctrl_ff};
                    tmc_pkg::IDX_BUF_A: begin
                        dat_o <= {24'h000000, tmr1_buffer_a_ff};
                    end
                    tmc_pkg::IDX_BUF_B: begin
                        dat_o <= {24'h000000, tmr1_buffer_b_ff};
                    end
                    tmc_pkg::IDX_STAT: dat_o <= {28'h0000000, stat_ff};
                    tmc_pkg::IDX_MASK: dat_o <= {28'h0000000, mask_ff};
                    tmc_pkg::IDX_COUNT: dat_o <= {24'h000000, count_ff};
                    default: dat_o <= '0;
                endcase
            end
        end
    end

    // checks
    property p_match_clear;
        @(posedge clk_i) disable iff (rst_i)
        match_ev |=> (count_ff == 8'h00) && stat_ff[tmc_pkg::ST_MATCH];
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("match did not clear counter");

    property p_soft_cap;
        @(posedge clk_i) disable iff (rst_i)
        (ctl.soft_cap && !capture_mode && !wr_lo)
            |=> !ctl.soft_cap && (tmr1_buffer_b_ff == $past(count_ff));
    endproperty
    a_soft_cap: assert property (p_soft_cap)
        else $error("soft capture failed");

    property p_capa;
        @(posedge clk_i) disable iff (rst_i)
        capa_ev |=> tmr1_buffer_a_ff == $past(count_ff)
            && count_ff == 8'h00 && cap_ff == tmc_pkg::TMC_HALTED;
    endproperty
    a_capa: assert property (p_capa)
        else $error("capture a wrong");

    property p_capb;
        @(posedge clk_i) disable iff (rst_i)
        capb_ev && !ctl.soft_cap |=> tmr1_buffer_b_ff == $past(count_ff);
    endproperty
    a_capb: assert property (p_capb)
        else $error("capture b wrong");

    property p_ovf;
        @(posedge clk_i) disable iff (rst_i)
        ovf_ev |=> tmr1_buffer_a_ff == 8'hFF && stat_ff[tmc_pkg::ST_OVF]
            && count_ff == 8'h00;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow handling wrong");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        cap_ff == tmc_pkg::TMC_HALTED && !rd_a && ctl.run
            |=> $stable(tmr1_buffer_a_ff) || $past(wr_lo);
    endproperty
    a_halt: assert property (p_halt)
        else $error("buffer a changed while halted");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
        !ctl.run ##1 !ctl.run |-> count_ff == 8'h00;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stopped counter not zero");

    property p_low_bits;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_ff[1:0] == 2'b00;
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("unused control bits set");

    property p_pin_count;
        @(posedge clk_i) disable iff (rst_i)
        ctl.run && !capture_mode && ctl.src == tmc_pkg::TMC_SRC_PIN
            && !sel_edge |=> $stable(count_ff) || $past(!ctl.run);
    endproperty
    a_pin_count: assert property (p_pin_count)
        else $error("counter moved without edge");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        |(stat_ff & mask_ff) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    c_match: cover property (@(posedge clk_i) disable iff (rst_i) match_ev);
    c_capa: cover property (@(posedge clk_i) disable iff (rst_i) capa_ev);
    c_ovf: cover property (@(posedge clk_i) disable iff (rst_i) ovf_ev);
    c_capb: cover property (@(posedge clk_i) disable iff (rst_i) capb_ev);
endmodule

/* test/tmc_pulse_src.sv */
// pulse source model that drives the timer input pin
`timescale 1ns/1ns
module tmc_pulse_src #(
    parameter int LAG = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // commanded level and driven pin
    input wire logic level_i,
    output logic tmr1_input_pin_o
);
    // delay line, the pin lags the command by lag clocks
    logic [LAG-1:0] dly_ff;
    // levels change only on command, each held whole clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_ff <= '0;
        end else begin
            dly_ff <= {dly_ff[LAG-2:0], level_i};
        end
    end
    // pin follows the oldest stage
    assign tmr1_input_pin_o = dly_ff[LAG-1];
endmodule

/* test/tb_tmc_timer1.sv */
// testbench: registers, counter, timer and capture behaviour of timer 1
`timescale 1ns/1ns
module tb_tmc_timer1;
    // clock, reset and bus drive
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    // design answers
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic irq;
    logic pin;
    logic level = 1'b0;
    // last read data and error flag
    logic [31:0] q;
    logic e;
    int n_mismatch = 0;
    int checks_done = 0;
    // design under test
    tmc_timer1 i_tmc_timer1 (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .err_o(err), .tmr1_input_pin_i(pin),
        .irq_o(irq));
    // far side pulse source
    tmc_pulse_src i_tmc_pulse_src (.clk_i(clk_i), .rst_i(rst_i),
        .level_i(level), .tmr1_input_pin_o(pin));
    // 25 mhz clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one classic wishbone cycle, waits for ack or err
    task automatic wb(input logic w, input logic [3:0] i,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
        end
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    // pin level then settle
    task automatic lvl(input logic v, input int hold);
        @(posedge clk_i);
        level <= v;
        repeat (hold) @(posedge clk_i);
    endtask
    // reset values, width and unmapped access
    task automatic t_reset();
        logic [3:0] idx [6];
        idx = '{tmc_pkg::IDX_CTRL, tmc_pkg::IDX_BUF_A, tmc_pkg::IDX_BUF_B,
               tmc_pkg::IDX_STAT, tmc_pkg::IDX_MASK, tmc_pkg::IDX_COUNT};
        foreach (idx[k]) begin
            wb(1'b0, idx[k], 8'h00);
            chk(q, 32'h0);
        end
        wb(1'b0, 4'hF, 8'h00);
        chk({31'h0, e}, 32'h1);
        wb(1'b1, tmc_pkg::IDX_BUF_B, 8'h5A);
        wb(1'b0, tmc_pkg::IDX_BUF_B, 8'h00);
        chk(q, 32'h5A);
    endtask
    // counter mode, rising edges, match, mask and sticky status
    task automatic t_counter();
        wb(1'b1, tmc_pkg::IDX_BUF_A, 8'h03);
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h70);
        for (int k = 0; k < 4; k++) begin
            lvl(1'b1, 6);
            lvl(1'b0, 6);
            if (k == 1) begin
                wb(1'b0, tmc_pkg::IDX_COUNT, 8'h00);
                chk(q, 32'h2);
            end
        end
        wb(1'b0, tmc_pkg::IDX_COUNT, 8'h00);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, tmc_pkg::IDX_MASK, 8'h01);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
        chk(q, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
    endtask
    // falling edge, control readback, soft capture and stop
    task automatic t_edge();
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h74);
        wb(1'b0, tmc_pkg::IDX_CTRL, 8'h00);
        chk(q, 32'h74);
        lvl(1'b1, 6);
        wb(1'b0, tmc_pkg::IDX_COUNT, 8'h00);
        chk(q, 32'h0);
        lvl(1'b0, 6);
        wb(1'b0, tmc_pkg::IDX_COUNT, 8'h00);
        chk(q, 32'h1);
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'hF4);
        wb(1'b0, tmc_pkg::IDX_BUF_B, 8'h00);
        chk(q, 32'h1);
        wb(1'b0, tmc_pkg::IDX_CTRL, 8'h00);
        chk(q, 32'h74);
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h00);
        wb(1'b0, tmc_pkg::IDX_COUNT, 8'h00);
        chk(q, 32'h0);
    endtask
    // timer mode match timing and prescale rates
    task automatic t_timer();
        int n;
        n = 0;
        wb(1'b1, tmc_pkg::IDX_BUF_A, 8'h02);
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h60);
        while (irq !== 1'b1 && n < 800) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, n >= 250 && n <= 400}, 32'h1);
        wb(1'b1, tmc_pkg::IDX_BUF_A, 8'hFF);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, tmc_pkg::IDX_CTRL, 8'h00);
            wb(1'b1, tmc_pkg::IDX_CTRL, k ? 8'h40 : 8'h50);
            repeat (2200) @(posedge clk_i);
            wb(1'b0, tmc_pkg::IDX_COUNT, 8'h00);
            chk({31'h0, q <= (k ? 1 : 3) && q >= (k ? 0 : 2)}, 32'h1);
        end
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h00);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
    endtask
    // capture mode: widths, halt and overflow
    task automatic t_capture();
        wb(1'b1, tmc_pkg::IDX_MASK, 8'h06);
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h68);
        lvl(1'b1, 6);
        wb(1'b0, tmc_pkg::IDX_BUF_A, 8'h00);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
        chk({31'h0, q[1]}, 32'h1);
        lvl(1'b1, 1260);
        lvl(1'b0, 768);
        lvl(1'b1, 6);
        chk({31'h0, irq}, 32'h1);
        lvl(1'b0, 300);
        lvl(1'b1, 6);
        wb(1'b0, tmc_pkg::IDX_BUF_B, 8'h00);
        chk({31'h0, q >= 9 && q <= 11}, 32'h1);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
        chk(q, 32'hA);
        wb(1'b0, tmc_pkg::IDX_BUF_A, 8'h00);
        chk({31'h0, q >= 15 && q <= 17}, 32'h1);
        repeat (33100) @(posedge clk_i);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
        chk({31'h0, q[2]}, 32'h1);
        wb(1'b0, tmc_pkg::IDX_BUF_A, 8'h00);
        chk(q, 32'hFF);
    endtask
    // capture mode with the falling edge as primary
    task automatic t_fall();
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h00);
        wb(1'b1, tmc_pkg::IDX_CTRL, 8'h6C);
        lvl(1'b0, 6);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
        chk(q, 32'h2);
        wb(1'b0, tmc_pkg::IDX_BUF_A, 8'h00);
        lvl(1'b1, 6);
        wb(1'b0, tmc_pkg::IDX_STAT, 8'h00);
        chk(q, 32'h8);
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_counter();
        t_edge();
        t_timer();
        t_capture();
        t_fall();
        results();
    end
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        results();
    end
endmodule
